// *** ebs_pkg.sv ***
// Shared constants and types for the external bus cycle phase sequencer
package ebs_pkg;

	// ----------------------------------------
	// Sizes and timing
	// ----------------------------------------
	localparam int EBS_SYS_CLK_PERIOD_NS = 25; // sys_clk_period at 40 MHz
	localparam int EBS_ADDR_W = 24;
	localparam int EBS_DATA_W = 16;
	localparam int EBS_CS_W = 2;
	localparam int EBS_NUM_CS = 4;
	localparam int EBS_CNT_W = 6;
	localparam logic [EBS_CNT_W-1:0] EBS_CNT_ONE = 6'h01;
	localparam logic [EBS_CNT_W-1:0] EBS_CNT_ZERO = 6'h00;

	// ----------------------------------------
	// Per chip-select timing configuration
	// ----------------------------------------
	// access_len holds the length minus one (0..31 means 1..32 periods).
	// addr_setup_len is the normal setup (1 or 2); addr_ext_len is added on a window change.
	typedef struct packed {
		logic mux_mode;
		logic ready_en;
		logic ready_async;
		logic ready_pol;
		logic [1:0] addr_setup_len;
		logic [1:0] addr_ext_len;
		logic [1:0] cmd_delay_len;
		logic wdata_setup_len;
		logic [4:0] access_len;
		logic [1:0] hold_len;
	} ebs_cfg_s;

	// ----------------------------------------
	// Request and pin groups
	// ----------------------------------------
	typedef struct packed {
		logic [EBS_CS_W-1:0] cs;
		logic wr;
		logic [EBS_ADDR_W-1:0] addr;
		logic [EBS_DATA_W-1:0] wdata;
	} ebs_req_s;

	typedef struct packed {
		logic [EBS_ADDR_W-1:0] addr;
		logic [EBS_NUM_CS-1:0] cs_n;
		logic ale;
		logic rd_n;
		logic wr_n;
		logic [EBS_DATA_W-1:0] data_out;
		logic data_oe;
	} ebs_bus_s;

	// ----------------------------------------
	// Cycle phases, one-hot
	// ----------------------------------------
	typedef enum logic [5:0] {
		EBS_PH_IDLE = 6'h01,
		EBS_PH_AB = 6'h02,
		EBS_PH_C = 6'h04,
		EBS_PH_D = 6'h08,
		EBS_PH_E = 6'h10,
		EBS_PH_F = 6'h20
	} ebs_phase_e;

endpackage

// *** ebs_ready_sync.sv ***
// Ready input synchroniser with selectable extra stage and polarity
`timescale 1ns/100ps
module ebs_ready_sync
	import ebs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ready_pin,
	input wire logic ready_async,
	input wire logic ready_pol,
	output logic ready_act
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} ebs_rsync_s;

	ebs_rsync_s s_r;
	ebs_rsync_s s_nxt;

	// ----------------------------------------
	// Stages
	// ----------------------------------------
	// s1 feeds only s2; s3 is the extra stage for asynchronous ready
	always_comb begin
		s_nxt.s1 = ready_pin;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Extra stage costs one more wait state when ready is asynchronous
	// Polarity applied after the flops, so samples taken before a polarity change are read with the new polarity until the stages refill
	assign ready_act = (ready_async ? s_r.s3 : s_r.s2) == ready_pol;

endmodule

// *** ebs_sequencer.sv ***
// External bus cycle phase sequencer: five ordered phases per bus cycle
// What this block does
// - Each cycle runs address setup, command delay, data setup, access, hold in order.
// - Phase lengths come from the selected chip select's timing configuration.
// - Address setup is 1 or 2 periods, plus 0 to 3 on window change.
// - Command delay and hold each last 0 to 3 periods.
// - Write data setup or mux tristate lasts 0 or 1 period.
// - Access lasts 1 to 32 periods, optionally stretched by ready.
// - Reference clock: ext_clk_output is the system clock while clk_out_en is set; bus_ref_clk_out only carries the clk_out_en level.
// - At the sample point, inactive ready adds a wait, active ready ends access.
// - Asynchronous ready takes an extra synchroniser stage, at least one wait.
// - Ready input polarity is configurable.
`timescale 1ns/100ps
module ebs_sequencer
	import ebs_pkg::*;
#(
	parameter int NUM_CS = EBS_NUM_CS
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire ebs_cfg_s chip_select_timing_config [NUM_CS],
	input wire logic req_valid,
	input wire ebs_req_s req,
	output logic req_ready,
	output logic done,
	output logic [EBS_DATA_W-1:0] rdata,
	output ebs_bus_s bus,
	input wire logic [EBS_DATA_W-1:0] data_in,
	input wire logic ready_pin,
	input wire logic clk_out_en,
	output logic ext_clk_output,
	output logic bus_ref_clk_out
);

	// ----------------------------------------
	// Phase length helpers
	// ----------------------------------------
	// Length in periods of a phase under a given configuration
	function automatic logic [EBS_CNT_W-1:0] phase_len(ebs_phase_e ph, ebs_cfg_s c, logic chg);
		logic [EBS_CNT_W-1:0] l;
		l = EBS_CNT_ZERO;
		case (ph)
			EBS_PH_AB: l = {4'h0, c.addr_setup_len} + (chg ? {4'h0, c.addr_ext_len} : EBS_CNT_ZERO);
			EBS_PH_C: l = {4'h0, c.cmd_delay_len};
			EBS_PH_D: l = {5'h00, c.wdata_setup_len};
			EBS_PH_E: l = {1'h0, c.access_len} + EBS_CNT_ONE;
			EBS_PH_F: l = {4'h0, c.hold_len};
			default: l = EBS_CNT_ZERO;
		endcase
		return l;
	endfunction

	// Next phase in the fixed order, skipping phases of zero length
	function automatic ebs_phase_e next_phase(ebs_phase_e ph, ebs_cfg_s c);
		ebs_phase_e p;
		p = EBS_PH_IDLE;
		case (ph)
			EBS_PH_AB: p = (c.cmd_delay_len != 2'h0) ? EBS_PH_C : (c.wdata_setup_len ? EBS_PH_D : EBS_PH_E);
			EBS_PH_C: p = c.wdata_setup_len ? EBS_PH_D : EBS_PH_E;
			EBS_PH_D: p = EBS_PH_E;
			EBS_PH_E: p = (c.hold_len != 2'h0) ? EBS_PH_F : EBS_PH_IDLE;
			default: p = EBS_PH_IDLE;
		endcase
		return p;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		ebs_phase_e ph;
		logic [EBS_CNT_W-1:0] cnt;
		ebs_cfg_s cfg;
		ebs_req_s rq;
		logic chg;
		logic have_last;
		logic [EBS_CS_W-1:0] last_cs;
		logic [EBS_DATA_W-1:0] din1;
		logic [EBS_DATA_W-1:0] din2;
		logic [EBS_DATA_W-1:0] rdata;
		logic done;
	} ebs_state_s;

	ebs_state_s s_r;
	ebs_state_s s_nxt;
	logic ready_act;
	logic phase_end;
	ebs_phase_e ph_after;

	ebs_ready_sync u_ready_sync (
		.clk(clk),
		.rst_n(rst_n),
		.ready_pin(ready_pin),
		.ready_async(s_r.cfg.ready_async),
		.ready_pol(s_r.cfg.ready_pol),
		.ready_act(ready_act)
	);

	assign phase_end = (s_r.cnt == EBS_CNT_ZERO);
	assign ph_after = next_phase(s_r.ph, s_r.cfg);

	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------
	// The configuration is latched at the start so a table change mid-cycle cannot tear a cycle
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.din1 = data_in;
		s_nxt.din2 = s_r.din1;
		case (s_r.ph)
			EBS_PH_IDLE: begin
				if (req_valid) begin
					s_nxt.cfg = chip_select_timing_config[req.cs];
					s_nxt.rq = req;
					s_nxt.chg = !s_r.have_last || (s_r.last_cs != req.cs);
					s_nxt.have_last = 1'b1;
					s_nxt.last_cs = req.cs;
					s_nxt.ph = EBS_PH_AB;
					s_nxt.cnt = phase_len(EBS_PH_AB, chip_select_timing_config[req.cs], s_nxt.chg) - EBS_CNT_ONE;
				end
			end
			EBS_PH_AB, EBS_PH_C, EBS_PH_D, EBS_PH_F: begin
				if (!phase_end) begin
					s_nxt.cnt = s_r.cnt - EBS_CNT_ONE;
				end else begin
					s_nxt.ph = ph_after;
					s_nxt.cnt = phase_len(ph_after, s_r.cfg, s_r.chg) - EBS_CNT_ONE;
					s_nxt.done = (ph_after == EBS_PH_IDLE);
				end
			end
			EBS_PH_E: begin
				if (!phase_end) begin
					s_nxt.cnt = s_r.cnt - EBS_CNT_ONE;
				end else if (!s_r.cfg.ready_en || ready_act) begin
					// Read data sampled two edges before the edge that ends the command, via din1 and din2
					s_nxt.rdata = s_r.din2;
					s_nxt.ph = ph_after;
					s_nxt.cnt = phase_len(ph_after, s_r.cfg, s_r.chg) - EBS_CNT_ONE;
					s_nxt.done = (ph_after == EBS_PH_IDLE);
				end
			end
			default: begin
				s_nxt.ph = EBS_PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.ph <= EBS_PH_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Pin and handshake outputs
	// ----------------------------------------
	// Outputs decode registered state only, so pins carry no combinational glitches
	assign req_ready = (s_r.ph == EBS_PH_IDLE);
	assign done = s_r.done;
	assign rdata = s_r.rdata;
	assign bus.addr = s_r.rq.addr;
	assign bus.ale = (s_r.ph == EBS_PH_AB);
	assign bus.rd_n = !((s_r.ph == EBS_PH_E) && !s_r.rq.wr);
	assign bus.wr_n = !((s_r.ph == EBS_PH_E) && s_r.rq.wr);
	// Chip select decode kept in its own vector so the pin struct has one kind of driver
	logic [EBS_NUM_CS-1:0] cs_dec;
	always_comb begin
		cs_dec = '1;
		for (int i = 0; i < EBS_NUM_CS; i++) begin
			if ((s_r.ph != EBS_PH_IDLE) && (s_r.rq.cs == i[EBS_CS_W-1:0])) begin
				cs_dec[i] = 1'b0;
			end
		end
	end
	assign bus.cs_n = cs_dec;
	// Multiplexed mode: address on data lines in setup, released in D for turnaround
	assign bus.data_out = (s_r.cfg.mux_mode && s_r.ph == EBS_PH_AB) ? s_r.rq.addr[EBS_DATA_W-1:0] : s_r.rq.wdata;
	assign bus.data_oe = (s_r.cfg.mux_mode && s_r.ph == EBS_PH_AB) ||
		(s_r.rq.wr && (s_r.ph == EBS_PH_E || s_r.ph == EBS_PH_F || (!s_r.cfg.mux_mode && s_r.ph == EBS_PH_D)));

	// ----------------------------------------
	// Reference clock output
	// ----------------------------------------
	// Clock routed as data; acceptable here because it only feeds the pad driver
	assign ext_clk_output = clk & clk_out_en;
	assign bus_ref_clk_out = clk_out_en;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// Cycles spent in the current phase, helper for the length checks
	logic [EBS_CNT_W-1:0] cyc_r;
	logic leaving;
	assign leaving = (s_nxt.ph != s_r.ph);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_r <= '0;
		end else begin
			cyc_r <= leaving ? EBS_CNT_ZERO : cyc_r + EBS_CNT_ONE;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_PHASE_ORDER: assert property (s_r.ph == EBS_PH_C |=> s_r.ph inside {EBS_PH_C, EBS_PH_D, EBS_PH_E})
		else $error("phase after command delay out of order");
	AST_CFG_SEL: assert property (req_valid && req_ready |=> s_r.cfg == $past(chip_select_timing_config[req.cs]))
		else $error("wrong chip select configuration taken");
	AST_AB_LEN: assert property (s_r.ph == EBS_PH_AB && leaving |->
		cyc_r + EBS_CNT_ONE == {4'h0, s_r.cfg.addr_setup_len} + (s_r.chg ? {4'h0, s_r.cfg.addr_ext_len} : EBS_CNT_ZERO))
		else $error("address setup length wrong");
	AST_CMD_LEN: assert property (s_r.ph == EBS_PH_C && leaving |-> cyc_r + EBS_CNT_ONE == {4'h0, s_r.cfg.cmd_delay_len})
		else $error("command delay length wrong");
	AST_HOLD_LEN: assert property (s_r.ph == EBS_PH_F && leaving |-> cyc_r + EBS_CNT_ONE == {4'h0, s_r.cfg.hold_len})
		else $error("hold length wrong");
	AST_WD_LEN: assert property (s_r.ph == EBS_PH_D |-> s_r.cfg.wdata_setup_len && leaving)
		else $error("data setup phase not one period");
	AST_ACC_LEN: assert property (s_r.ph == EBS_PH_E && leaving |->
		(s_r.cfg.ready_en ? cyc_r >= {1'h0, s_r.cfg.access_len} : cyc_r == {1'h0, s_r.cfg.access_len}))
		else $error("access length wrong");
	AST_WAIT_NOT_READY: assert property (s_r.ph == EBS_PH_E && phase_end && s_r.cfg.ready_en && !ready_act
		|=> s_r.ph == EBS_PH_E && !bus.rd_n == !s_r.rq.wr)
		else $error("access ended without ready");
	AST_READY_ENDS: assert property (s_r.ph == EBS_PH_E && phase_end && ready_act |=> s_r.ph != EBS_PH_E)
		else $error("ready did not end access");
	AST_SKIP_ZERO: assert property (s_r.ph == EBS_PH_AB && leaving && s_r.cfg.cmd_delay_len == 2'h0
		|=> s_r.ph != EBS_PH_C)
		else $error("zero length command delay not skipped");

	COV_READY_WAIT: cover property (s_r.ph == EBS_PH_E && phase_end && s_r.cfg.ready_en && !ready_act ##1 ready_act);
	COV_MUX_WRITE: cover property (s_r.ph == EBS_PH_D && s_r.cfg.mux_mode && s_r.rq.wr);
	COV_BACK_TO_BACK: cover property (done ##1 s_r.ph == EBS_PH_AB && !s_r.chg);
	COV_WINDOW_CHG: cover property (s_r.ph == EBS_PH_AB && s_r.chg && s_r.cfg.addr_ext_len == 2'h3);

endmodule

// *** ebs_mem_model.sv ***
// Behavioural external memory: read data and ready handshake
`timescale 1ns/100ps
module ebs_mem_model
	import ebs_pkg::*;
(
	input wire logic clk,
	input wire ebs_bus_s bus,
	input wire logic ready_pol,
	input wire logic [3:0] ready_dly,
	output logic [EBS_DATA_W-1:0] data_in,
	output logic ready_pin
);
	logic [EBS_DATA_W-1:0] idle_r = 16'h0000;
	logic [3:0] cnt_r = 4'h0;
	logic cmd;
	// ----------------
	// Pins
	// ----------------
	// Released data toggles every cycle so a stale capture cannot pass
	assign cmd = !(bus.rd_n && bus.wr_n);
	assign data_in = bus.rd_n ? idle_r : (bus.addr[15:0] ^ 16'hA5C3);
	// Ready falls with the command, clear before the next sample point
	assign ready_pin = (cmd && cnt_r >= ready_dly) ? ready_pol : !ready_pol;
	// Count command cycles, saturating so ready never drops back
	always @(posedge clk) begin
		idle_r <= ~data_in;
		cnt_r <= !cmd ? 4'h0 : (cnt_r == 4'hF ? cnt_r : cnt_r + 4'h1);
	end
endmodule

// *** ebs_sequencer_test.sv ***
// Randomised bus cycle checks for the phase sequencer
`timescale 1ns/100ps
module ebs_sequencer_test;
	import ebs_pkg::*;
	localparam ebs_cfg_s CMAX = '{1'b0, 1'b0, 1'b0, 1'b0, 2'h2, 2'h3, 2'h3, 1'b1, 5'h1F, 2'h3};
	localparam ebs_cfg_s CMIN = '{1'b1, 1'b0, 1'b0, 1'b0, 2'h1, 2'h0, 2'h0, 1'b0, 5'h00, 2'h0};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic clk_out_en = 1'b0;
	logic [3:0] ready_dly = 4'h0;
	ebs_req_s req = '0;
	ebs_cfg_s cfg [EBS_NUM_CS] = '{default: '0};
	logic req_ready, done, ext_clk_output, bus_ref_clk_out, ready_pin;
	logic [EBS_DATA_W-1:0] rdata, data_in;
	ebs_bus_s bus;
	logic [31:0] seed = 32'hAE0B201A;
	int fails = 0;
	int check_count = 0;
	int cycles = 0;
	int prev_cs = -1;

	always #12.5 clk = ~clk;

	ebs_sequencer #(.NUM_CS(EBS_NUM_CS)) DUT (.clk(clk), .rst_n(rst_n), .chip_select_timing_config(cfg),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done), .rdata(rdata), .bus(bus),
		.data_in(data_in), .ready_pin(ready_pin), .clk_out_en(clk_out_en), .ext_clk_output(ext_clk_output),
		.bus_ref_clk_out(bus_ref_clk_out));
	ebs_mem_model mem (.clk(clk), .bus(bus), .ready_pol(cfg[req.cs].ready_pol), .ready_dly(ready_dly),
		.data_in(data_in), .ready_pin(ready_pin));

	// ----------------
	// Helpers
	// ----------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Access cycles under ready: programmed length, or ready delay plus synchroniser depth plus one
	function automatic int acc_cycles(input int e, input int dly, input logic async_rdy);
		int r;
		r = dly + 3 + async_rdy;
		return (e > r) ? e : r;
	endfunction

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard, far above the longest planned run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			end_of_test();
		end
	end

	// One bus cycle: present at a falling edge, watch phases until done
	task automatic run_one(input ebs_cfg_s c, input ebs_req_s r, input logic [3:0] dly, input logic en);
		int ab, e, n, na, ne, st;
		logic pol_chg;
		ab = c.addr_setup_len + ((r.cs != prev_cs) ? c.addr_ext_len : 0);
		e = c.access_len + 1;
		n = 0;
		na = 0;
		ne = 0;
		st = 0;
		pol_chg = (cfg[req.cs].ready_pol != c.ready_pol);
		cfg[r.cs] = c;
		req = r;
		ready_dly = dly;
		clk_out_en = en;
		// A polarity flip makes the old idle level look active; let the synchroniser refill first
		if (pol_chg) repeat (3) @(negedge clk);
		req_valid = 1'b1;
		repeat (50) if (req_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		#1;
		chk({ext_clk_output, bus_ref_clk_out}, {2{en}});
		do begin
			@(negedge clk);
			if (n == 0) req_valid = 1'b0;
			n++;
			na += (bus.ale === 1'b1);
			if (bus.ale === 1'b1 && c.mux_mode) chk({bus.data_oe, bus.data_out}, {1'b1, r.addr[15:0]});
			if (c.wdata_setup_len && n == ab + c.cmd_delay_len + 1) chk(bus.data_oe, r.wr & !c.mux_mode);
			if (bus.rd_n === 1'b0 || bus.wr_n === 1'b0) begin
				ne++;
				if (st == 0) st = n;
				chk(bus.cs_n, 4'(~(4'h1 << r.cs)));
				if (r.wr) chk({bus.data_oe, bus.data_out}, {1'b1, r.wdata});
				else chk(bus.data_oe, 1'b0);
			end
		end while (done !== 1'b1 && n < 200);
		chk(done, 1'b1);
		chk(bus.addr, r.addr);
		chk(na, ab);
		chk(st, ab + c.cmd_delay_len + c.wdata_setup_len + 1);
		chk(n - ne, ab + c.cmd_delay_len + c.wdata_setup_len + c.hold_len + 1);
		if (!c.ready_en) chk(ne, e);
		else chk(ne, acc_cycles(e, dly, c.ready_async));
		chk({bus.cs_n, bus.rd_n, bus.wr_n, bus.data_oe, req_ready}, {4'hF, 4'hD});
		if (!r.wr && ne >= 3) chk(rdata, r.addr[15:0] ^ 16'hA5C3);
		prev_cs = r.cs;
	endtask

	// ----------------
	// Main sequence
	// ----------------
	initial begin
		logic [63:0] w;
		ebs_cfg_s c;
		repeat (20) @(posedge clk);
		chk({req_ready, done, bus.cs_n, bus.ale, bus.data_oe}, 8'hBC);
		@(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		// Longest phases, then shortest with skipped phases, back to back
		run_one(CMAX, {2'h1, 1'b1, 24'h00ABCD, 16'h1234}, 4'h0, 1'b1);
		run_one(CMIN, {2'h1, 1'b1, 24'h0000F0, 16'hBEEF}, 4'h0, 1'b0);
		run_one(CMIN, {2'h1, 1'b0, 24'h000F00, 16'h0000}, 4'h0, 1'b1);
		repeat (300) begin
			w = {rnd(), rnd()};
			c = w[63:46];
			c.addr_setup_len = {w[45], !w[45]};
			c.ready_en = w[44] & w[43];
			// Ready cases mix both polarities and both synchroniser depths
			run_one(c, w[42:0], {2'h0, c.addr_ext_len ^ c.cmd_delay_len}, c.mux_mode ^ c.hold_len[1]);
			if (c.hold_len[0] ^ c.wdata_setup_len) @(negedge clk);
		end
		end_of_test();
	end
endmodule
